// File: src/cssrc_top.sv
// Clock speed selection and reset control with an APB register slave
// Operation
// - Setting the CPU double-speed bit gives 6 oscillator periods per machine cycle, else 12.
// - A clear peripheral speed bit gives that peripheral 6 periods per cycle, a set one 12.
// - While the CPU double-speed bit is low all peripherals run at 12 periods per cycle.
// - Speed bits sit at 7 CAN, 6 watchdog, 5 counter array, 4 serial, 3..1 timers 2..0.
// - Any reset loads the clock speed register with zeros, so standard speed is used.
// - In double speed a fast peripheral sees its time reference halved.
// - A pin reset is accepted only after the pin is held for 24 oscillator periods.
// - The hold qualification counts raw oscillator periods whatever the speed mode.
// - A watchdog expiry drives a 96 period reset pulse onto the reset pin.
// - A warm reset comes from the pin or from the watchdog, counter array or timers.
// - Both modes share one oscillator counter whose low bit forms the halved clock.
// - A new CPU speed bit takes effect only at a falling edge of the halved clock.
`timescale 1ns/1ps
`default_nettype none
module cssrc_top
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic apb_psel_in,
  input wire logic apb_penable_in,
  input wire logic apb_pwrite_in,
  input wire logic [cssrc_pkg::CSSRC_ADDR_W-1:0] apb_paddr_in,
  input wire logic [31:0] apb_pwdata_in,
  output logic [31:0] apb_prdata_out,
  output logic apb_pready_out,
  output logic apb_pslverr_out,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_out,
  input wire logic wdt_expire_in,
  input wire logic cntarr_rst_in,
  input wire logic timer_rst_in,
  output logic warm_rst_out,
  output logic cpu_cycle_en_out,
  output logic [cssrc_pkg::CSSRC_NUM_PERIPH-1:0] periph_tick_out,
  output logic double_speed_out
);
  import cssrc_pkg::*;
  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0] ckctl_q;
  logic [7:0] ckctl_d;
  cssrc_mode_t mode_q;
  cssrc_mode_t mode_d;
  logic [3:0] cause_q;
  logic [3:0] cause_d;
  logic warm_rst_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic cpu_en_q;
  logic [CSSRC_NUM_PERIPH-1:0] periph_q;
  logic pin_oe_q;
  logic pin_drv_q;
  logic [CSSRC_NUM_PERIPH-1:0] periph_d;
  wire logic tick_std;
  wire logic tick_dbl;
  wire logic half_edge;
  wire logic pin_held;
  wire logic wdt_drive;
  wire logic double_w;
  wire logic cpu_en_d;
  wire logic access_w;
  wire logic done_w;
  wire logic hit_ckctl;
  wire logic hit_status;
  wire logic mapped_w;
  wire logic wr_ckctl;
  wire logic wr_status;
  wire logic warm_src;
  wire logic [3:0] cause_set;
  wire logic [3:0] cause_clr;
  wire logic [31:0] rd_mux;
  // ************************************************************
  // Rate counter and reset qualifier
  // ************************************************************
  cssrc_rate_gen u_rate
  (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .tick_std_out(tick_std),
    .tick_dbl_out(tick_dbl),
    .half_edge_out(half_edge)
  );
  cssrc_rst_qual u_rstq
  (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .rst_pin_in(rst_pin_in),
    .wdt_expire_in(wdt_expire_in),
    .pin_held_out(pin_held),
    .wdt_drive_out(wdt_drive)
  );
  // ************************************************************
  // APB decode
  // ************************************************************
  assign access_w = apb_psel_in & apb_penable_in;
  assign done_w = access_w & pready_q;
  assign hit_ckctl = (apb_paddr_in == CSSRC_CKSEL_ADDR);
  assign hit_status = (apb_paddr_in == CSSRC_STATUS_ADDR);
  assign mapped_w = hit_ckctl | hit_status;
  assign wr_ckctl = done_w & apb_pwrite_in & hit_ckctl;
  assign wr_status = done_w & apb_pwrite_in & hit_status;
  assign rd_mux = hit_ckctl ? {24'h000000, ckctl_q} :
                  hit_status ? {27'h0000000, cause_q, double_w} : 32'h00000000;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= access_w & ~pready_q;
      pslverr_q <= access_w & ~pready_q & ~mapped_w;
      prdata_q <= (access_w & ~pready_q & ~apb_pwrite_in) ? rd_mux : 32'h00000000;
    end
  end
  // ************************************************************
  // Clock speed register and effective mode
  // ************************************************************
  assign ckctl_d = warm_rst_q ? CSSRC_CKSEL_RST :
                   wr_ckctl ? apb_pwdata_in[7:0] : ckctl_q;
  assign mode_d = warm_rst_q ? CSSRC_STANDARD_SPEED_MODE :
                  half_edge ? cssrc_mode_t'(ckctl_q[CSSRC_CPU_DOUBLE_SPEED_BIT]) : mode_q;
  assign double_w = (mode_q == CSSRC_DOUBLE_SPEED_MODE);
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ckctl_q <= CSSRC_CKSEL_RST;
      mode_q <= CSSRC_STANDARD_SPEED_MODE;
    end
    else
    begin
      ckctl_q <= ckctl_d;
      mode_q <= mode_d;
    end
  end
  // ************************************************************
  // Machine cycle and peripheral time bases
  // ************************************************************
  assign cpu_en_d = double_w ? tick_dbl : tick_std;
  generate
    for (genvar i = 0; i < CSSRC_NUM_PERIPH; i++)
    begin : g_periph
      assign periph_d[i] = (double_w & ~ckctl_q[i+1]) ? tick_dbl : tick_std;
    end
  endgenerate
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cpu_en_q <= 1'b0;
      periph_q <= '0;
    end
    else
    begin
      cpu_en_q <= cpu_en_d;
      periph_q <= periph_d;
    end
  end
  // ************************************************************
  // Warm reset, reset cause and pin drive
  // ************************************************************
  assign warm_src = pin_held | wdt_expire_in | cntarr_rst_in | timer_rst_in;
  assign cause_set = {timer_rst_in, cntarr_rst_in, wdt_expire_in, pin_held};
  assign cause_clr = wr_status ? apb_pwdata_in[4:1] : 4'h0;
  assign cause_d = (cause_q & ~cause_clr) | cause_set;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      warm_rst_q <= 1'b0;
      cause_q <= CSSRC_CAUSE_RST;
      pin_oe_q <= 1'b0;
      pin_drv_q <= 1'b0;
    end
    else
    begin
      warm_rst_q <= warm_src;
      cause_q <= cause_d;
      pin_oe_q <= wdt_drive;
      pin_drv_q <= wdt_drive;
    end
  end
  // ************************************************************
  // Outputs
  // ************************************************************
  assign apb_prdata_out = prdata_q;
  assign apb_pready_out = pready_q;
  assign apb_pslverr_out = pslverr_q;
  assign rst_pin_out = pin_drv_q;
  assign rst_pin_oe_out = pin_oe_q;
  assign warm_rst_out = warm_rst_q;
  assign cpu_cycle_en_out = cpu_en_q;
  assign periph_tick_out = periph_q;
  assign double_speed_out = double_w;
  // ************************************************************
  // Check helpers
  // ************************************************************
  logic [4:0] cfg_age_q;
  logic [7:0] oe_len_q;
  logic [7:0] ckctl_prev_q;
  logic mode_prev_q;
  logic [3:0] cpu_gap_q;
  wire logic cfg_settled;
  assign cfg_settled = (cfg_age_q >= 5'd16);
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cfg_age_q <= 5'h00;
      oe_len_q <= 8'h00;
      ckctl_prev_q <= 8'h00;
      mode_prev_q <= 1'b0;
      cpu_gap_q <= 4'h0;
    end
    else
    begin
      ckctl_prev_q <= ckctl_q;
      mode_prev_q <= double_w;
      if (ckctl_prev_q != ckctl_q || mode_prev_q != double_w)
        cfg_age_q <= 5'h00;
      else if (cfg_age_q != 5'h1f)
        cfg_age_q <= cfg_age_q + 5'h01;
      oe_len_q <= rst_pin_oe_out ? oe_len_q + 8'h01 : 8'h00;
      if (cpu_cycle_en_out)
        cpu_gap_q <= 4'h0;
      else if (cpu_gap_q != 4'hf)
        cpu_gap_q <= cpu_gap_q + 4'h1;
    end
  end
  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);
  cpu_std_rate_a: assert property (
    cfg_settled && !double_w && cpu_cycle_en_out |-> ##12 cpu_cycle_en_out)
    else $error("standard machine cycle is not 12 periods");
  cpu_std_gap_a: assert property (
    cfg_settled && !double_w |-> cpu_cycle_en_out == (cpu_gap_q == CSSRC_STD_LAST))
    else $error("extra machine cycle pulse in standard mode");
  cpu_dbl_rate_a: assert property (
    cfg_settled && double_w |-> cpu_cycle_en_out == (cpu_gap_q == CSSRC_DBL_LAST))
    else $error("double speed machine cycle is not 6 periods");
  periph_fast_a: assert property (
    cfg_settled && double_w && !ckctl_q[CSSRC_TIMER0_SPEED_SEL_BIT] && periph_tick_out[0]
    |-> $past(periph_tick_out[0], 6))
    else $error("fast peripheral tick is not 6 periods");
  periph_slow_a: assert property (
    cfg_settled && double_w && ckctl_q[CSSRC_CAN_SPEED_SEL_BIT] && periph_tick_out[6]
    |-> !$past(periph_tick_out[6], 6))
    else $error("slow peripheral ticks at the fast rate");
  periph_ignore_a: assert property (
    cfg_settled && !double_w |-> periph_tick_out == {CSSRC_NUM_PERIPH{cpu_cycle_en_out}})
    else $error("peripheral speed bit honoured in standard mode");
  mode_edge_a: assert property (
    double_w != mode_prev_q |-> $past(half_edge) || $past(warm_rst_q))
    else $error("speed mode changed off the halved clock edge");
  reg_reset_a: assert property (
    warm_rst_q |=> ckctl_q == CSSRC_CKSEL_RST && !double_w)
    else $error("warm reset did not clear the speed register");
  wdt_pulse_a: assert property (
    $fell(rst_pin_oe_out) |-> oe_len_q == 8'(CSSRC_WDT_PULSE_CYC))
    else $error("watchdog pin pulse has the wrong length");
  wdt_start_a: assert property (
    wdt_expire_in && !rst_pin_oe_out && !wdt_drive |-> ##2 rst_pin_oe_out && rst_pin_out)
    else $error("watchdog expiry did not drive the pin");
  internal_src_a: assert property (
    wdt_expire_in || cntarr_rst_in || timer_rst_in |=> warm_rst_out)
    else $error("internal reset source ignored");
  pin_qual_a: assert property (
    rst_pin_in [*8] ##1 rst_pin_in [*8] ##1 rst_pin_in [*8] ##1 rst_pin_in [*3]
    |-> ##1 warm_rst_out)
    else $error("held reset pin not accepted");
  mode_switch_c: cover property (!double_w ##1 double_w);
  wdt_pulse_c: cover property ($fell(rst_pin_oe_out));
  pin_reset_c: cover property ($rose(pin_held));
  fast_tick_c: cover property (double_w && periph_tick_out[0] && !periph_tick_out[6]);
endmodule : cssrc_top
`default_nettype wire

// File: inc/cssrc_pkg.sv
// Constants and types shared by the clock speed and reset control block
`default_nettype none
package cssrc_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam int CSSRC_ADDR_W = 12;
  localparam logic [7:0] CSSRC_CKSEL_IDX = 8'h8f;
  localparam logic [7:0] CSSRC_STATUS_IDX = 8'h90;
  localparam logic [CSSRC_ADDR_W-1:0] CSSRC_CKSEL_ADDR = {2'h0, CSSRC_CKSEL_IDX, 2'h0};
  localparam logic [CSSRC_ADDR_W-1:0] CSSRC_STATUS_ADDR = {2'h0, CSSRC_STATUS_IDX, 2'h0};
  localparam logic [7:0] CSSRC_CKSEL_RST = 8'h00;
  localparam logic [3:0] CSSRC_CAUSE_RST = 4'h0;
  // ************************************************************
  // Field positions of clock_speed_select
  // ************************************************************
  localparam int CSSRC_CPU_DOUBLE_SPEED_BIT = 0;
  localparam int CSSRC_TIMER0_SPEED_SEL_BIT = 1;
  localparam int CSSRC_TIMER1_SPEED_SEL_BIT = 2;
  localparam int CSSRC_TIMER2_SPEED_SEL_BIT = 3;
  localparam int CSSRC_SERIAL_SPEED_SEL_BIT = 4;
  localparam int CSSRC_COUNTER_ARRAY_SPEED_SEL_BIT = 5;
  localparam int CSSRC_WATCHDOG_SPEED_SEL_BIT = 6;
  localparam int CSSRC_CAN_SPEED_SEL_BIT = 7;
  localparam int CSSRC_NUM_PERIPH = 7;
  // ************************************************************
  // Status fields
  // ************************************************************
  localparam int CSSRC_CAUSE_PIN_BIT = 0;
  localparam int CSSRC_CAUSE_WDT_BIT = 1;
  localparam int CSSRC_CAUSE_CNTARR_BIT = 2;
  localparam int CSSRC_CAUSE_TMR_BIT = 3;
  // ************************************************************
  // Timing, in oscillator periods and in clock cycles
  // ************************************************************
  localparam int CSSRC_OSC_PERIOD_NS = 40;
  localparam int CSSRC_CLK_PERIOD_NS = 40;
  localparam int CSSRC_OSC_PER_STD = 12;
  localparam int CSSRC_OSC_PER_DBL = 6;
  localparam int CSSRC_RST_MIN_OSC = 24;
  localparam int CSSRC_WDT_PULSE_OSC = 96;
  localparam int CSSRC_RST_MIN_CYC =
    (CSSRC_RST_MIN_OSC * CSSRC_OSC_PERIOD_NS + CSSRC_CLK_PERIOD_NS - 1) / CSSRC_CLK_PERIOD_NS;
  localparam int CSSRC_WDT_PULSE_CYC =
    (CSSRC_WDT_PULSE_OSC * CSSRC_OSC_PERIOD_NS) / CSSRC_CLK_PERIOD_NS;
  localparam logic [3:0] CSSRC_STD_LAST = 4'(CSSRC_OSC_PER_STD - 1);
  localparam logic [3:0] CSSRC_DBL_LAST = 4'(CSSRC_OSC_PER_DBL - 1);
  localparam logic [4:0] CSSRC_RST_MIN_CNT = 5'(CSSRC_RST_MIN_CYC);
  localparam logic [6:0] CSSRC_WDT_PULSE_CNT = 7'(CSSRC_WDT_PULSE_CYC);
  // ************************************************************
  // Modes
  // ************************************************************
  typedef enum logic
  {
    CSSRC_STANDARD_SPEED_MODE = 1'b0,
    CSSRC_DOUBLE_SPEED_MODE = 1'b1
  } cssrc_mode_t;
endpackage : cssrc_pkg
`default_nettype wire

// File: src/cssrc_rate_gen.sv
// Common oscillator counter giving 6 and 12 period tick pulses
`timescale 1ns/1ps
`default_nettype none
module cssrc_rate_gen
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  output logic tick_std_out,
  output logic tick_dbl_out,
  output logic half_edge_out
);
  import cssrc_pkg::*;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  wire logic at_std_last;
  wire logic at_dbl_last;
  // ************************************************************
  // Counter over one standard machine cycle
  // ************************************************************
  assign at_std_last = (cnt_q == CSSRC_STD_LAST);
  assign at_dbl_last = (cnt_q == CSSRC_DBL_LAST);
  assign cnt_d = at_std_last ? 4'h0 : cnt_q + 4'h1;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_d;
  end
  // ************************************************************
  // Tick pulses and divided clock edge
  // ************************************************************
  assign tick_std_out = at_std_last;
  assign tick_dbl_out = at_std_last | at_dbl_last;
  assign half_edge_out = cnt_q[0];
endmodule : cssrc_rate_gen
`default_nettype wire

// File: src/cssrc_rst_qual.sv
// Reset pin qualification and watchdog reset pulse generation
`timescale 1ns/1ps
`default_nettype none
module cssrc_rst_qual
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic rst_pin_in,
  input wire logic wdt_expire_in,
  output logic pin_held_out,
  output logic wdt_drive_out
);
  import cssrc_pkg::*;
  logic pin_s1_q;
  logic pin_s2_q;
  logic [4:0] hold_q;
  logic [6:0] drive_q;
  wire logic hold_full;
  // ************************************************************
  // Pin synchroniser and hold counter
  // ************************************************************
  assign hold_full = (hold_q == CSSRC_RST_MIN_CNT);
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      hold_q <= 5'h00;
    end
    else
    begin
      pin_s1_q <= rst_pin_in;
      pin_s2_q <= pin_s1_q;
      if (!pin_s2_q)
        hold_q <= 5'h00;
      else if (!hold_full)
        hold_q <= hold_q + 5'h01;
    end
  end
  assign pin_held_out = hold_full;
  // ************************************************************
  // Watchdog pulse onto the pin
  // ************************************************************
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      drive_q <= 7'h00;
    else if (wdt_expire_in && drive_q == 7'h00)
      drive_q <= CSSRC_WDT_PULSE_CNT;
    else if (drive_q != 7'h00)
      drive_q <= drive_q - 7'h01;
  end
  assign wdt_drive_out = (drive_q != 7'h00);
  // ************************************************************
  // Checks
  // ************************************************************
  short_hold_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !pin_s2_q |=> !pin_held_out)
    else $error("reset accepted without a held pin");
endmodule : cssrc_rst_qual
`default_nettype wire

// File: sim/cssrc_pin_model.sv
// Reset pin circuitry model: external push source, pull-down and device drive
`timescale 1ns/1ps
`default_nettype none
module cssrc_pin_model
(
  input wire logic press_in,
  input wire logic dev_out_in,
  input wire logic dev_oe_in,
  output logic pin_out
);
  // ************************************************************
  // Wire level
  // ************************************************************
  // Pull-down keeps the pin low unless some party drives it high
  assign pin_out = press_in | (dev_oe_in & dev_out_in);
endmodule : cssrc_pin_model
`default_nettype wire

// File: sim/cssrc_top_tb.sv
// Self-checking testbench of the clock speed and reset control block
`timescale 1ns/1ps
`default_nettype none
module cssrc_top_tb;
  import cssrc_pkg::*;
  typedef struct {logic [7:0] cfg; int cpu_per;} cssrc_row_t;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in, psel, penable, pwrite, press, wdt, carr, tmr;
  logic [CSSRC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, pin_drv, pin_oe, warm, cpu_en, dbl;
  logic [CSSRC_NUM_PERIPH-1:0] ptick;
  wire logic pin_lvl;
  wire logic [9:0] allv = {warm, pin_oe, cpu_en, ptick};
  int bad_count = 0;
  int comparisons = 0;
  int per;
  logic [31:0] rd;
  logic err;
  cssrc_row_t rows [7] = '{'{8'h00, 12}, '{8'h01, 6}, '{8'hff, 6}, '{8'hfe, 12},
    '{8'h55, 6}, '{8'haa, 12}, '{8'h81, 6}};
  always #20 clk_sys_in = ~clk_sys_in;
  cssrc_top uut
  (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .apb_psel_in(psel),
    .apb_penable_in(penable), .apb_pwrite_in(pwrite), .apb_paddr_in(paddr),
    .apb_pwdata_in(pwdata), .apb_prdata_out(prdata), .apb_pready_out(pready),
    .apb_pslverr_out(pslverr), .rst_pin_in(pin_lvl), .rst_pin_out(pin_drv),
    .rst_pin_oe_out(pin_oe), .wdt_expire_in(wdt), .cntarr_rst_in(carr),
    .timer_rst_in(tmr), .warm_rst_out(warm), .cpu_cycle_en_out(cpu_en),
    .periph_tick_out(ptick), .double_speed_out(dbl)
  );
  cssrc_pin_model pin
  (
    .press_in(press), .dev_out_in(pin_drv), .dev_oe_in(pin_oe), .pin_out(pin_lvl)
  );
  // ************************************************************
  // Tasks
  // ************************************************************
  task report_and_stop;
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : check_word
  task wait_sig(input int idx, input logic lvl, input int lim);
    int n;
    n = 0;
    while (allv[idx] !== lvl && n < lim)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (n == lim)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_sig
  task apb_xfer(input logic wr, input logic [CSSRC_ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    @(posedge clk_sys_in);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n == 20)
    begin
      bad_count++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer
  task reg_check(input logic [CSSRC_ADDR_W-1:0] a, input logic [31:0] exp, input logic e);
    apb_xfer(1'b0, a, 32'h0);
    check_word(rd, exp);
    check_word({31'h0, err}, {31'h0, e});
  endtask : reg_check
  task measure(input int idx, output int p);
    wait_sig(idx, 1'b1, 40);
    @(posedge clk_sys_in);
    #1;
    p = 1;
    while (allv[idx] !== 1'b1 && p < 40)
    begin
      @(posedge clk_sys_in);
      #1;
      p++;
    end
  endtask : measure
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    sys_rst_in = 1'b1;
    {psel, penable, pwrite, press, wdt, carr, tmr} = 7'h00;
    paddr = '0;
    pwdata = 32'h0;
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    check_word({30'h0, warm, dbl}, 32'h0);
    reg_check(CSSRC_CKSEL_ADDR, 32'h0, 1'b0);
    foreach (rows[r])
    begin
      apb_xfer(1'b1, CSSRC_CKSEL_ADDR, {24'h0, rows[r].cfg});
      reg_check(CSSRC_CKSEL_ADDR, {24'h0, rows[r].cfg}, 1'b0);
      repeat (30) @(posedge clk_sys_in);
      #1;
      check_word({31'h0, dbl}, {31'h0, rows[r].cfg[0]});
      measure(7, per);
      check_word(32'(per), 32'(rows[r].cpu_per));
      for (int i = 0; i < CSSRC_NUM_PERIPH; i++)
      begin
        measure(i, per);
        check_word(32'(per), (rows[r].cfg[0] && !rows[r].cfg[i+1]) ? 32'd6 : 32'd12);
      end
    end
    apb_xfer(1'b1, 12'h008, 32'hff);
    check_word({31'h0, err}, 32'h1);
    reg_check(12'h004, 32'h0, 1'b1);
    reg_check(CSSRC_CKSEL_ADDR, 32'h81, 1'b0);
    apb_xfer(1'b1, CSSRC_CKSEL_ADDR, 32'h01);
    @(posedge clk_sys_in);
    press <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    press <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    #1;
    check_word({31'h0, warm}, 32'h0);
    @(posedge clk_sys_in);
    press <= 1'b1;
    repeat (23) @(posedge clk_sys_in);
    #1;
    check_word({31'h0, warm}, 32'h0);
    wait_sig(9, 1'b1, 10);
    @(posedge clk_sys_in);
    press <= 1'b0;
    wait_sig(9, 1'b0, 20);
    reg_check(CSSRC_CKSEL_ADDR, 32'h0, 1'b0);
    @(posedge clk_sys_in);
    wdt <= 1'b1;
    @(posedge clk_sys_in);
    wdt <= 1'b0;
    #1;
    check_word({31'h0, warm}, 32'h1);
    wait_sig(8, 1'b1, 10);
    check_word({31'h0, pin_drv}, 32'h1);
    per = 0;
    while (pin_oe === 1'b1 && per < 200)
    begin
      @(posedge clk_sys_in);
      #1;
      per++;
    end
    check_word(32'(per), 32'(CSSRC_WDT_PULSE_OSC));
    wait_sig(9, 1'b0, 200);
    for (int j = 0; j < 2; j++)
    begin
      @(posedge clk_sys_in);
      if (j == 0)
        carr <= 1'b1;
      else
        tmr <= 1'b1;
      @(posedge clk_sys_in);
      {carr, tmr} <= 2'b00;
      #1;
      check_word({31'h0, warm}, 32'h1);
      wait_sig(9, 1'b0, 50);
    end
    reg_check(CSSRC_STATUS_ADDR, 32'h1e, 1'b0);
    apb_xfer(1'b1, CSSRC_STATUS_ADDR, 32'h1e);
    apb_xfer(1'b1, CSSRC_CKSEL_ADDR, 32'hff);
    repeat (4) @(posedge clk_sys_in);
    reg_check(CSSRC_STATUS_ADDR, 32'h01, 1'b0);
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
    #1;
    check_word({22'h0, allv}, 32'h0);
    check_word({31'h0, dbl}, 32'h0);
    reg_check(CSSRC_CKSEL_ADDR, 32'h0, 1'b0);
    reg_check(CSSRC_STATUS_ADDR, 32'h0, 1'b0);
    report_and_stop();
  end
endmodule : cssrc_top_tb
`default_nettype wire
